// file: led_dim_pkg.sv
// Shared constants for the LED dimming and pump ratio control block
package led_dim_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ          = 40_000_000;  // System clock rate
    localparam int unsigned SHDN_DELAY_US   = 500;         // Disable detect delay, us
    localparam int unsigned DWELL_US        = 1000;        // Dwell in 1.5x before 2x, us
    localparam int unsigned RETRY_MS        = 130;         // Periodic ratio retry, ms
    localparam int unsigned SOFT_START_US   = 400;         // Soft start time, us
    localparam int unsigned SHDN_CYC        = (CLK_HZ / 1_000_000) * SHDN_DELAY_US;
    localparam int unsigned DWELL_CYC       = (CLK_HZ / 1_000_000) * DWELL_US;
    localparam int unsigned RETRY_CYC       = (CLK_HZ / 1_000) * RETRY_MS;
    localparam int unsigned SS_CYC          = (CLK_HZ / 1_000_000) * SOFT_START_US;
    localparam int unsigned TMR_W           = 24;          // Width of every timer

    // ****************************************
    // Dimming levels
    // ****************************************
    localparam int unsigned NUM_LEVELS      = 11;          // Steps 100% down to 5%
    localparam logic [3:0]  LEVEL_FULL      = 4'h0;        // Index 0 is 100%
    localparam logic [3:0]  LEVEL_LAST      = 4'hA;        // Index 10 is 5%
    localparam logic [6:0]  PCT_FULL        = 7'h64;       // 100 percent
    localparam logic [6:0]  PCT_STEP        = 7'h0A;       // 10 percent per step
    localparam logic [6:0]  PCT_MIN         = 7'h05;       // Floor of 5 percent

    // ****************************************
    // Pump ratio codes
    // ****************************************
    typedef enum logic [2:0] {
        RATIO_1X  = 3'h1,
        RATIO_15X = 3'h2,
        RATIO_2X  = 3'h4
    } ratio_e;
endpackage : led_dim_pkg

// file: led_dim_ctrl.sv
// Two-input pulse dimming, shutdown, fault and pump ratio control
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1 - 1x while nodes high, else 1.5x
// R2 - Dwell 1 ms in 1.5x before 2x
// R3 - From 1.5x retry 1x every 130 ms (code retries only when output below input)
// R4 - 1.5x to 2x only on dropout
// R5 - 2x falls back periodically or on disable
// R6 - First main rise enables at 100%
// R7 - Pulses step down 10%, last 5%, wrap
// R8 - Sub group has own identical counter
// R9 - Tied enables step all six together
// R10 - Host resets level by long low
// R11 - Host sends burst within 2-3 ms
// R12 - Low 0.5 ms turns group off
// R13 - Both low 0.5 ms: full shutdown
// R14 - Output below 1.2 V: short mode
// R15 - Open channel: clamp, others keep running
// R16 - Disable channels with high sink voltage
// R17 - Overtemperature shuts down, recovers automatically
// R18 - Host holds first pulse 50 us
// R19 - Host low pulse 0.5 to 250 us
// R20 - Host high time at least 0.5 us
// R21 - Shutdown delay timed from falling edge
// R22 - Count short lows as level steps
// R23 - Off groups sinks disabled, level ignored
module led_dim_ctrl
    import led_dim_pkg::*;
#(
    parameter int unsigned SHDN_CYCLES  = SHDN_CYC,   // Disable detect delay
    parameter int unsigned DWELL_CYCLES = DWELL_CYC,  // 1.5x dwell before 2x
    parameter int unsigned RETRY_CYCLES = RETRY_CYC,  // Ratio retry period
    parameter int unsigned SS_CYCLES    = SS_CYC      // Soft start length
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    // Pulse enable pins, asynchronous
    input  wire logic        main_group_enable_i,
    input  wire logic        sub_group_enable_i,
    // Analog comparator flags, asynchronous
    input  wire logic [5:0]  sink_low_i,          // Channel sink node below 150 mV
    input  wire logic [5:0]  sink_dropout_i,      // Channel sink node in dropout
    input  wire logic [5:0]  sink_unused_i,       // Sink above output or supply minus 0.4 V
    input  wire logic        out_below_in_i,      // Pump output below supply input
    input  wire logic        out_short_i,         // Pump output below 1.2 V
    input  wire logic        out_overvolt_i,      // Pump output reached 6 V
    input  wire logic        over_temp_i,         // Junction above 165 C
    // Channel and pump control
    output logic [5:0]       sink_enable_o,       // Per channel sink on
    output logic [6:0]       main_level_pct_o,    // Main group current percent
    output logic [6:0]       sub_level_pct_o,     // Sub group current percent
    output logic [2:0]       pump_ratio_o,        // One-hot pump ratio
    output logic             pump_run_o,          // Pump switching allowed
    output logic             soft_start_o,        // Soft start in progress
    output logic             shutdown_o,          // Full shutdown mode
    output logic             short_mode_o         // Short circuit mode
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [2:0]       m_sync;     // Main enable synchroniser
        logic [2:0]       s_sync;     // Sub enable synchroniser
        logic [2:0][5:0]  low_sync;   // Low node synchroniser
        logic [2:0][5:0]  drop_sync;  // Dropout synchroniser
        logic [2:0][5:0]  unu_sync;   // Unused sink synchroniser
        logic [2:0][3:0]  flg_sync;   // Short, ovp, temp, below-in
        logic             m_lvl;      // Filtered main enable
        logic             s_lvl;      // Filtered sub enable
        logic [5:0]       low;        // Filtered flags
        logic [5:0]       drop;
        logic [5:0]       unu;
        logic [3:0]       flg;
        logic             m_on;       // Main group enabled
        logic             s_on;       // Sub group enabled
        logic [3:0]       m_idx;      // Main level index
        logic [3:0]       s_idx;      // Sub level index
        logic [TMR_W-1:0] m_low_t;    // Main low time
        logic [TMR_W-1:0] s_low_t;    // Sub low time
        logic [TMR_W-1:0] ss_t;       // Soft start timer
        logic             ss_act;
        logic [TMR_W-1:0] mode_t;     // Dwell or retry timer
        ratio_e           ratio;
        logic             dwell_done; // 1.5x dwell passed
        logic             shdn;
    } st_s;

    st_s st;
    st_s next_st;

    // ****************************************
    // Helpers
    // ****************************************
    // Index to percent: 100 - 10*idx, floor 5
    function automatic logic [6:0] idx_to_pct(input logic [3:0] idx);
        logic [6:0] dec;
        dec = 7'(idx) * PCT_STEP;
        if (idx >= LEVEL_LAST) begin
            idx_to_pct = PCT_MIN;
        end else begin
            idx_to_pct = PCT_FULL - dec;
        end
    endfunction : idx_to_pct

    // Step the level with wrap after the last one
    function automatic logic [3:0] idx_step(input logic [3:0] idx);
        if (idx >= LEVEL_LAST) begin
            idx_step = LEVEL_FULL;
        end else begin
            idx_step = idx + 4'h1;
        end
    endfunction : idx_step

    // Saturating timer increment
    function automatic logic [TMR_W-1:0] tinc(input logic [TMR_W-1:0] t);
        tinc = (&t) ? t : t + TMR_W'(1);
    endfunction : tinc

    // ****************************************
    // Next state
    // ****************************************
    // Filtering, dimming, shutdown and ratio control
    always_comb begin
        logic m_rise;
        logic s_rise;
        logic m_dis;
        logic s_dis;
        logic any_low;
        logic any_drop;
        logic fault_off;
        logic chan_drop;
        logic [5:0] act;
        next_st  = st;
        m_rise   = 1'b0;
        s_rise   = 1'b0;
        m_dis    = 1'b0;
        s_dis    = 1'b0;
        fault_off = 1'b0;
        act      = 6'h00;
        any_low  = 1'b0;
        any_drop = 1'b0;
        chan_drop = 1'b0;

        // Three-stage synchronisers, last two must agree
        next_st.m_sync    = {st.m_sync[1:0], main_group_enable_i};
        next_st.s_sync    = {st.s_sync[1:0], sub_group_enable_i};
        next_st.low_sync  = {st.low_sync[1:0], sink_low_i};
        next_st.drop_sync = {st.drop_sync[1:0], sink_dropout_i};
        next_st.unu_sync  = {st.unu_sync[1:0], sink_unused_i};
        next_st.flg_sync  = {st.flg_sync[1:0],
                             {out_below_in_i, over_temp_i, out_overvolt_i, out_short_i}};
        if (st.m_sync[2] == st.m_sync[1]) begin
            next_st.m_lvl = st.m_sync[2];
        end
        if (st.s_sync[2] == st.s_sync[1]) begin
            next_st.s_lvl = st.s_sync[2];
        end
        for (int i = 0; i < 6; i++) begin
            if (st.low_sync[2][i] == st.low_sync[1][i]) next_st.low[i] = st.low_sync[2][i];
            if (st.drop_sync[2][i] == st.drop_sync[1][i]) next_st.drop[i] = st.drop_sync[2][i];
            if (st.unu_sync[2][i] == st.unu_sync[1][i]) next_st.unu[i] = st.unu_sync[2][i];
        end
        for (int i = 0; i < 4; i++) begin
            if (st.flg_sync[2][i] == st.flg_sync[1][i]) next_st.flg[i] = st.flg_sync[2][i];
        end

        // R21 - Low timers from falling edge
        next_st.m_low_t = st.m_lvl ? '0 : tinc(st.m_low_t);
        next_st.s_low_t = st.s_lvl ? '0 : tinc(st.s_low_t);
        // R12 - Long low disables group
        m_dis = !st.m_lvl && (st.m_low_t >= TMR_W'(SHDN_CYCLES));
        s_dis = !st.s_lvl && (st.s_low_t >= TMR_W'(SHDN_CYCLES));
        if (m_dis) next_st.m_on = 1'b0;
        if (s_dis) next_st.s_on = 1'b0;
        // R13 - Both disabled means shutdown
        if (m_dis && s_dis) next_st.shdn = 1'b1;
        chan_drop = (m_dis && st.m_on && st.s_lvl) || (s_dis && st.s_on && st.m_lvl);

        m_rise = next_st.m_lvl && !st.m_lvl;
        s_rise = next_st.s_lvl && !st.s_lvl;

        // R6 - Rise from off restarts at 100%
        if (m_rise && (!st.m_on || m_dis)) begin
            next_st.m_on  = 1'b1;
            next_st.m_idx = LEVEL_FULL;
        // R22 - Short low is a step
        end else if (m_rise) begin
            // R7 - Step and wrap
            next_st.m_idx = idx_step(st.m_idx);
        end
        // R8 - Sub group, own counter
        // R9 - Tied pins step both alike
        if (s_rise && (!st.s_on || s_dis)) begin
            next_st.s_on  = 1'b1;
            next_st.s_idx = LEVEL_FULL;
        end else if (s_rise) begin
            next_st.s_idx = idx_step(st.s_idx);
        end

        // Leaving shutdown starts a soft start
        if ((m_rise || s_rise) && next_st.shdn) begin
            next_st.shdn   = 1'b0;
            next_st.ss_act = 1'b1;
            next_st.ss_t   = '0;
        end else if (st.ss_act) begin
            next_st.ss_t = tinc(st.ss_t);
            if (st.ss_t >= TMR_W'(SS_CYCLES)) next_st.ss_act = 1'b0;
        end

        // R14 - Short and R17 - over temperature stop the pump
        fault_off = st.flg[0] || st.flg[2];
        // R16 - Active channels exclude unused sinks
        act = {{2{st.s_on}}, {4{st.m_on}}} & ~st.unu;
        any_low  = |(st.low & act);
        any_drop = |(st.drop & act);

        // Pump ratio selection
        next_st.mode_t = tinc(st.mode_t);
        if (next_st.shdn || fault_off || st.ss_act) begin
            next_st.ratio      = RATIO_1X;
            next_st.mode_t     = '0;
            next_st.dwell_done = 1'b0;
        end else begin
            unique case (st.ratio)
                RATIO_1X: begin
                    // R1 - Low node raises ratio
                    if (any_low) begin
                        next_st.ratio      = RATIO_15X;
                        next_st.mode_t     = '0;
                        next_st.dwell_done = 1'b0;
                    end
                end
                RATIO_15X: begin
                    // R2 - Dwell before 2x allowed
                    if (st.mode_t >= TMR_W'(DWELL_CYCLES)) next_st.dwell_done = 1'b1;
                    // R4 - Dropout moves to 2x
                    if (st.dwell_done && any_drop) begin
                        next_st.ratio  = RATIO_2X;
                        next_st.mode_t = '0;
                    // R3 - Periodic 1x retry
                    end else if (st.flg[3] && st.mode_t >= TMR_W'(RETRY_CYCLES)) begin
                        next_st.ratio  = RATIO_1X;
                        next_st.mode_t = '0;
                    end
                end
                RATIO_2X: begin
                    // R5 - Periodic or disable fallback
                    if (st.mode_t >= TMR_W'(RETRY_CYCLES) || chan_drop) begin
                        next_st.ratio      = RATIO_15X;
                        next_st.mode_t     = '0;
                        next_st.dwell_done = 1'b1;
                    end
                end
                default: begin
                    next_st.ratio = RATIO_1X;
                end
            endcase
        end
    end

    // ****************************************
    // Register
    // ****************************************
    // Single state register, synchronous reset
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st       <= '0;
            st.ratio <= RATIO_1X;
            st.shdn  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // R23 - Off groups, unused sinks, shutdown and over temperature gate sinks
    // R15 - Overvoltage leaves other channels running
    assign sink_enable_o    = ({{2{st.s_on}}, {4{st.m_on}}} & ~st.unu)
                              & {6{!st.shdn && !st.flg[2]}};
    assign main_level_pct_o = st.m_on ? idx_to_pct(st.m_idx) : 7'h00;
    assign sub_level_pct_o  = st.s_on ? idx_to_pct(st.s_idx) : 7'h00;
    assign pump_ratio_o     = st.ratio;
    // R14 - Short mode halts the pump
    assign pump_run_o       = !st.shdn && !st.flg[0] && !st.flg[2] && !st.flg[1];
    assign soft_start_o     = st.ss_act;
    assign shutdown_o       = st.shdn;
    assign short_mode_o     = st.flg[0];

endmodule : led_dim_ctrl
`default_nettype wire

// file: led_dim_ctrl_properties.sv
// Port checks for the dimming and pump ratio control
`timescale 1ns/1ps
`default_nettype none
module led_dim_ctrl_properties
    import led_dim_pkg::*;
#(
    parameter int unsigned SHDN_CYCLES  = SHDN_CYC,
    parameter int unsigned DWELL_CYCLES = DWELL_CYC
) (
    // Clock, reset, main enable pin and fault inputs
    input wire logic       sys_clk_i,
    input wire logic       rstn_i,
    input wire logic       main_group_enable_i,
    input wire logic [5:0] sink_unused_i,
    input wire logic       over_temp_i,
    // Block outputs
    input wire logic [5:0] sink_enable_o,
    input wire logic [6:0] main_level_pct_o,
    input wire logic [6:0] sub_level_pct_o,
    input wire logic [2:0] pump_ratio_o,
    input wire logic       pump_run_o,
    input wire logic       soft_start_o,
    input wire logic       shutdown_o
);
    // ****************************************
    // Helper counters
    // ****************************************
    logic [TMR_W-1:0] dwell_cnt;    // Cycles in 1.5x since leaving 1x
    logic [TMR_W-1:0] main_lo_cnt;  // Cycles the main pin has been low
    // Dwell count survives 2x, cleared only in 1x
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || pump_ratio_o == RATIO_1X) begin
            dwell_cnt <= '0;
        end else if (pump_ratio_o == RATIO_15X && !(&dwell_cnt)) begin
            dwell_cnt <= dwell_cnt + TMR_W'(1);
        end
    end
    // Raw pin low time, saturating
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || main_group_enable_i) begin
            main_lo_cnt <= '0;
        end else if (!(&main_lo_cnt)) begin
            main_lo_cnt <= main_lo_cnt + TMR_W'(1);
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    // Percent after one pulse; 5 wraps to 100
    function automatic logic [6:0] next_pct(input logic [6:0] p);
        return (p == PCT_MIN) ? PCT_FULL : (p == PCT_STEP) ? PCT_MIN : p - PCT_STEP;
    endfunction : next_pct
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    main_step_a: assert property ($changed(main_level_pct_o) &&
        $past(main_level_pct_o) != 7'h00 && main_level_pct_o != 7'h00 |->
        main_level_pct_o == next_pct($past(main_level_pct_o))) else $error("main step wrong");
    sub_step_a: assert property ($changed(sub_level_pct_o) &&
        $past(sub_level_pct_o) != 7'h00 && sub_level_pct_o != 7'h00 |->
        sub_level_pct_o == next_pct($past(sub_level_pct_o))) else $error("sub step wrong");
    shdn_all_off_a: assert property (shutdown_o |-> sink_enable_o == 6'h00 &&
        !pump_run_o && pump_ratio_o == RATIO_1X) else $error("shutdown with output on");
    wake_full_a: assert property ($fell(shutdown_o) |-> ##[0:2] (soft_start_o &&
        (main_level_pct_o == PCT_FULL || sub_level_pct_o == PCT_FULL))) else $error("bad wake");
    no_skip_a: assert property (pump_ratio_o == RATIO_1X |=> pump_ratio_o != RATIO_2X)
        else $error("1x went to 2x");
    dwell_hold_a: assert property (pump_ratio_o == RATIO_1X ##1 pump_ratio_o == RATIO_15X
        |-> (pump_ratio_o != RATIO_2X) [*8]) else $error("dwell cut short");
    dwell_time_a: assert property (pump_ratio_o == RATIO_15X ##1 pump_ratio_o == RATIO_2X |->
        dwell_cnt >= TMR_W'(DWELL_CYCLES)) else $error("2x before dwell");
    main_off_a: assert property (main_lo_cnt >= TMR_W'(SHDN_CYCLES + 8) |->
        main_level_pct_o == 7'h00 && sink_enable_o[3:0] == 4'h0) else $error("main on after low");
    hot_off_a: assert property (over_temp_i [*8] |-> sink_enable_o == 6'h00 &&
        !pump_run_o) else $error("output on while hot");
    unused_off_a: assert property ($stable(sink_unused_i) [*8] |->
        (sink_unused_i & sink_enable_o) == 6'h00) else $error("unused sink on");
endmodule : led_dim_ctrl_properties
bind led_dim_ctrl led_dim_ctrl_properties #(
    .SHDN_CYCLES(SHDN_CYCLES), .DWELL_CYCLES(DWELL_CYCLES)) u_props (.*);
`default_nettype wire

// file: host_pulse_model.sv
// Host GPIO model driving the two group enable pins
`timescale 1ns/1ps
`default_nettype none
module host_pulse_model #(
    parameter int unsigned LONG_LO = 60  // Beyond the disable delay
) (
    // Pacing clock
    input  wire logic sys_clk_i,
    // Group enable pins
    output logic      main_pin_o,
    output logic      sub_pin_o
);
    // ****************************************
    // Pin timing
    // ****************************************
    localparam int unsigned STEP_T  = 20;    // 0.5 us low or high
    localparam int unsigned FIRST_T = 2000;  // 50 us first high
    initial begin
        main_pin_o = 1'b0;
        sub_pin_o  = 1'b0;
    end
    // Set chosen pins, then wait n edges
    task automatic hold(input logic [1:0] pins, input logic lvl, input int unsigned n);
        if (pins[0]) main_pin_o = lvl;
        if (pins[1]) sub_pin_o = lvl;
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : hold
    // short low is a step; bursts stay far inside 2 ms
    task automatic step(input logic [1:0] pins);
        hold(pins, 1'b0, STEP_T);
        hold(pins, 1'b1, STEP_T);
    endtask : step
    // long low, then long first high
    task automatic wake(input logic [1:0] pins);
        hold(pins, 1'b0, LONG_LO);
        hold(pins, 1'b1, FIRST_T);
    endtask : wake
endmodule : host_pulse_model
`default_nettype wire

// file: tb.sv
// Self-checking bench for the dimming and pump ratio control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
    import led_dim_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam int unsigned SHDN  = 40;   // Shrunk disable delay
    localparam int unsigned DWELL = 80;   // Shrunk 1.5x dwell
    localparam int unsigned RETRY = 200;  // Shrunk ratio retry period
    localparam int unsigned SS    = 20;   // Shrunk soft start
    logic sys_clk_i = 1'b0;
    logic rstn_i;
    logic main_pin, sub_pin;
    logic [5:0] sink_low, sink_drop, sink_unused, sink_en;
    logic below_in, short_in, ovp_in, hot_in;
    logic [6:0] main_pct, sub_pct;
    logic [2:0] ratio;
    logic pump_run, soft_start, shdn, short_mode;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    host_pulse_model #(.LONG_LO(SHDN + 20)) u_host (.sys_clk_i(sys_clk_i),
        .main_pin_o(main_pin), .sub_pin_o(sub_pin));
    led_dim_ctrl #(.SHDN_CYCLES(SHDN), .DWELL_CYCLES(DWELL), .RETRY_CYCLES(RETRY),
        .SS_CYCLES(SS)) u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .main_group_enable_i(main_pin), .sub_group_enable_i(sub_pin),
        .sink_low_i(sink_low), .sink_dropout_i(sink_drop), .sink_unused_i(sink_unused),
        .out_below_in_i(below_in), .out_short_i(short_in), .out_overvolt_i(ovp_in),
        .over_temp_i(hot_in), .sink_enable_o(sink_en), .main_level_pct_o(main_pct),
        .sub_level_pct_o(sub_pct), .pump_ratio_o(ratio), .pump_run_o(pump_run),
        .soft_start_o(soft_start), .shutdown_o(shdn), .short_mode_o(short_mode));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic cyc(input int unsigned n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : cyc
    // Poll the ratio with a bound, then compare
    task automatic wait_ratio(input logic [2:0] r, input int unsigned lim);
        int unsigned n;
        n = 0;
        while (ratio !== r && n < lim) begin
            cyc(1);
            n++;
        end
        `CHK("pump ratio", r, ratio)
    endtask : wait_ratio
    // Wake main, walk all eleven levels and wrap
    task automatic t_main;
        logic [6:0] e;
        u_host.wake(2'b01);
        `CHK("shutdown", 1'b0, shdn)
        `CHK("main pct", PCT_FULL, main_pct)
        `CHK("sinks", 6'h0F, sink_en)
        for (int i = 1; i <= 11; i++) begin
            u_host.step(2'b01);
            e = (i == 11) ? PCT_FULL : (i == 10) ? PCT_MIN : 7'(PCT_FULL - PCT_STEP * i);
            `CHK("main step", e, main_pct)
        end
    endtask : t_main
    // Sub group keeps its own count
    task automatic t_sub;
        u_host.wake(2'b10);
        u_host.step(2'b10);
        u_host.step(2'b10);
        `CHK("sub pct", 7'h50, sub_pct)
        `CHK("main kept", PCT_FULL, main_pct)
    endtask : t_sub
    // One group dropped, then restarted at full
    task automatic t_one_off;
        u_host.hold(2'b01, 1'b0, SHDN - 20);
        `CHK("main held", PCT_FULL, main_pct)
        cyc(40);
        `CHK("main off", 7'h00, main_pct)
        `CHK("main sinks", 4'h0, sink_en[3:0])
        `CHK("no shutdown", 1'b0, shdn)
        u_host.wake(2'b01);
        `CHK("main restart", PCT_FULL, main_pct)
    endtask : t_one_off
    // Both dropped, then tied pins set an absolute level
    task automatic t_tied;
        u_host.hold(2'b11, 1'b0, SHDN + 20);
        `CHK("shutdown", 1'b1, shdn)
        `CHK("pump run", 1'b0, pump_run)
        u_host.hold(2'b11, 1'b0, SHDN + 20);
        u_host.hold(2'b11, 1'b1, 10);
        `CHK("soft start", 1'b1, soft_start)
        u_host.hold(2'b11, 1'b1, 1990);
        `CHK("soft start done", 1'b0, soft_start)
        repeat (7) u_host.step(2'b11);
        `CHK("main abs", 7'h1E, main_pct)
        `CHK("sub abs", 7'h1E, sub_pct)
    endtask : t_tied
    // Ratio climb, dwell, fallbacks and retry
    task automatic t_ratio;
        `CHK("ratio idle", RATIO_1X, ratio)
        sink_low = 6'h01;
        wait_ratio(RATIO_15X, 20);
        sink_drop = 6'h01;
        cyc(40);
        `CHK("ratio dwell", RATIO_15X, ratio)
        wait_ratio(RATIO_2X, 100);
        u_host.hold(2'b10, 1'b0, 4);
        wait_ratio(RATIO_15X, SHDN + 20);
        wait_ratio(RATIO_2X, 20);
        sink_low = 6'h00;
        sink_drop = 6'h00;
        wait_ratio(RATIO_15X, 220);
        below_in = 1'b1;
        wait_ratio(RATIO_1X, 420);
        cyc(20);
        `CHK("ratio stays", RATIO_1X, ratio)
        below_in = 1'b0;
    endtask : t_ratio
    // Heat, short, overvoltage and unused channel
    task automatic t_faults;
        hot_in = 1'b1;
        cyc(10);
        `CHK("hot sinks", 6'h00, sink_en)
        hot_in = 1'b0;
        cyc(10);
        `CHK("cool sinks", 6'h0F, sink_en)
        short_in = 1'b1;
        cyc(10);
        `CHK("short mode", 1'b1, short_mode)
        `CHK("short pump", 1'b0, pump_run)
        short_in = 1'b0;
        cyc(10);
        `CHK("short gone", 1'b0, short_mode)
        ovp_in = 1'b1;
        cyc(10);
        `CHK("ovp pump", 1'b0, pump_run)
        `CHK("ovp sinks", 6'h0F, sink_en)
        ovp_in = 1'b0;
        sink_unused = 6'h02;
        cyc(10);
        `CHK("unused sink", 6'h0D, sink_en)
    endtask : t_faults
    task automatic end_sim;
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // Hang guard
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        rstn_i      = 1'b0;
        sink_low    = 6'h00;
        sink_drop   = 6'h00;
        sink_unused = 6'h00;
        below_in    = 1'b0;
        short_in    = 1'b0;
        ovp_in      = 1'b0;
        hot_in      = 1'b0;
        cyc(16);
        rstn_i = 1'b1;
        cyc(2);
        `CHK("reset shutdown", 1'b1, shdn)
        t_main();
        t_sub();
        t_one_off();
        t_tied();
        t_ratio();
        t_faults();
        end_sim();
    end
endmodule : tb
`default_nettype wire
